// File: rtl/ic2h_top.v
// i2c host sequencer: axi4-lite command registers driving the controller's registers
//
// Summary of operation
// - program clock divider before any transfer
// - program own slave address at init
// - set module enable before serial transfers
// - then choose master, direction, interrupt enable
// - stuck busy: run six-step stop recovery
// - wait bus idle before requesting start
// - first data byte is address plus direction
// - after address, poll until bus busy
// - clear pending flag first on service
// - poll pending flag, not byte complete
// - after address cycle, read switches to receive
// - addressed as slave: direction follows slave bit
// - slave data cycles ignore slave direction bit
// - check acknowledge after each transmitted byte
`include "ic2h_map.vh"
module ic2h_top #(
  parameter ADDR_W = 8
) (
  // clock, reset, enable
  input wire clock,
  input wire rst,
  input wire ce,
  // axi4-lite write channels
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read channels
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // device register port
  output wire dev_req,
  output wire dev_we,
  output wire [2:0] dev_addr,
  output wire [7:0] dev_wdata,
  input wire dev_ack,
  input wire [7:0] dev_rdata,
  input wire dev_irq
);
  localparam S_IDLE = 5'd0;
  localparam S_I_DIV = 5'd1;
  localparam S_I_ADR = 5'd2;
  localparam S_I_EN = 5'd3;
  localparam S_I_CHK = 5'd4;
  localparam S_R1 = 5'd5;
  localparam S_R2 = 5'd6;
  localparam S_R3 = 5'd7;
  localparam S_R4 = 5'd8;
  localparam S_R5 = 5'd9;
  localparam S_R6 = 5'd10;
  localparam S_I_MODE = 5'd11;
  localparam S_S_POLL = 5'd12;
  localparam S_S_TX = 5'd13;
  localparam S_S_MS = 5'd14;
  localparam S_S_AD = 5'd15;
  localparam S_S_BB = 5'd16;
  localparam S_W_IRQ = 5'd17;
  localparam S_W_ST = 5'd18;
  localparam S_W_CLR = 5'd19;
  localparam S_S_RX = 5'd20;
  localparam S_S_DUM = 5'd21;
  localparam S_X_DAT = 5'd22;
  localparam S_Q_DAT = 5'd23;
  localparam S_P = 5'd24;
  localparam S_V_MTX = 5'd25;

  reg [4:0] state_reg;
  reg [2:0] op_reg;
  reg pend_reg;
  reg [7:0] div_reg;
  reg [7:0] own_reg;
  reg ien_reg;
  reg [7:0] tx_reg;
  reg [7:0] rx_reg;
  reg [7:0] st_reg;
  reg done_flag_reg;
  reg nack_reg;
  reg arb_reg;
  reg stuck_reg;
  reg addressed_as_slave_flag_reg;
  reg srw_reg;
  reg irq_m_reg;
  reg irq_s_reg;
  reg aw_have_reg;
  reg w_have_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg acc_we;
  reg [2:0] acc_addr;
  reg [7:0] acc_wdata;
  reg acc_need;
  wire acc_done;
  wire [7:0] acc_rdata;
  wire acc_go;
  wire busy;

  // control byte from the enable, interrupt choice and mode bits
  function [7:0] ctrl_byte;
    input module_enable_bit;
    input master_select_bit;
    input transmit_select_bit;
    begin
      ctrl_byte = 8'h00;
      ctrl_byte[`IC2H_CB_EN] = 1'b1;
      ctrl_byte[`IC2H_CB_IEN] = module_enable_bit;
      ctrl_byte[`IC2H_CB_MASTER_SELECT_BIT] = master_select_bit;
      ctrl_byte[`IC2H_CB_MTX] = transmit_select_bit;
    end
  endfunction

  // word-aligned byte address of a byte address
  function [ADDR_W-1:0] word_addr;
    input [ADDR_W-1:0] a;
    begin
      word_addr = {a[ADDR_W-1:2], 2'b00};
    end
  endfunction

  assign busy = (state_reg != S_IDLE);
  assign acc_go = acc_need && !pend_reg;

  // ****************************************
  // device access for each step
  // ****************************************
  always @*
  begin
    acc_need = 1'b1;
    acc_we = 1'b1;
    acc_addr = `IC2H_DEV_CTRL;
    acc_wdata = 8'h00;
    case (state_reg)
      S_I_DIV:
      begin
        acc_addr = `IC2H_DEV_DIV;
        acc_wdata = div_reg;
      end
      S_I_ADR:
      begin
        acc_addr = `IC2H_DEV_OWN;
        acc_wdata = own_reg;
      end
      S_I_EN, S_R6:
      begin
        acc_wdata = 8'h00;
        acc_wdata[`IC2H_CB_EN] = 1'b1;
      end
      S_I_CHK, S_S_POLL, S_S_BB, S_W_ST:
      begin
        acc_we = 1'b0;
        acc_addr = `IC2H_DEV_STAT;
      end
      S_R1, S_R5:
        acc_wdata = `IC2H_CTRL_OFF;
      S_R2:
        acc_wdata = `IC2H_CTRL_RECOVER;
      S_R3, S_S_DUM, S_Q_DAT:
      begin
        acc_we = 1'b0;
        acc_addr = `IC2H_DEV_DATA;
      end
      S_R4:
      begin
        acc_addr = `IC2H_DEV_STAT;
        acc_wdata = 8'h00;
      end
      S_I_MODE, S_P:
        acc_wdata = ctrl_byte(ien_reg, 1'b0, 1'b0);
      S_S_TX:
        acc_wdata = ctrl_byte(ien_reg, 1'b0, 1'b1);
      S_S_MS:
        acc_wdata = ctrl_byte(ien_reg, 1'b1, 1'b1);
      S_S_AD, S_X_DAT:
      begin
        acc_addr = `IC2H_DEV_DATA;
        acc_wdata = tx_reg;
      end
      S_W_CLR:
      begin
        acc_addr = `IC2H_DEV_STAT;
        acc_wdata = st_reg & `IC2H_STAT_CLR_MASK;
      end
      S_S_RX:
        acc_wdata = ctrl_byte(ien_reg, 1'b1, 1'b0);
      S_V_MTX:
        acc_wdata = ctrl_byte(ien_reg, 1'b0, srw_reg);
      default:
        acc_need = 1'b0;
    endcase
  end

  ic2h_devport u_port (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .go(acc_go),
    .acc_we(acc_we),
    .acc_addr(acc_addr),
    .acc_wdata(acc_wdata),
    .done(acc_done),
    .rdata_reg(acc_rdata),
    .dev_req(dev_req),
    .dev_we(dev_we),
    .dev_addr(dev_addr),
    .dev_wdata(dev_wdata),
    .dev_ack(dev_ack),
    .dev_rdata(dev_rdata)
  );

  // ****************************************
  // sequencer
  // ****************************************
  // a command written while busy is dropped; software waits for the done flag
  always @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      op_reg <= 3'h0;
      pend_reg <= 1'b0;
      rx_reg <= 8'h00;
      st_reg <= 8'h00;
      done_flag_reg <= 1'b0;
      nack_reg <= 1'b0;
      arb_reg <= 1'b0;
      stuck_reg <= 1'b0;
      addressed_as_slave_flag_reg <= 1'b0;
      srw_reg <= 1'b0;
      irq_m_reg <= 1'b0;
      irq_s_reg <= 1'b0;
    end
    else if (ce)
    begin
      irq_m_reg <= dev_irq;
      irq_s_reg <= irq_m_reg;
      if (acc_go)
        pend_reg <= 1'b1;
      if (state_reg == S_IDLE)
      begin
        if (aw_have_reg && w_have_reg && !s_axi_bvalid && w_strb_reg[0] &&
            word_addr(aw_addr_reg) == `IC2H_A_CMD)
        begin
          case (w_data_reg[2:0])
            `IC2H_OP_INIT: state_reg <= S_I_DIV;
            `IC2H_OP_START: state_reg <= S_S_POLL;
            `IC2H_OP_WRITE: state_reg <= S_X_DAT;
            `IC2H_OP_READ: state_reg <= S_W_IRQ;
            `IC2H_OP_STOP: state_reg <= S_P;
            `IC2H_OP_SLAVE: state_reg <= S_W_IRQ;
            default: state_reg <= S_IDLE;
          endcase
          op_reg <= w_data_reg[2:0];
          done_flag_reg <= 1'b0;
        end
      end
      else if (state_reg == S_W_IRQ)
      begin
        if (!ien_reg || irq_s_reg)
          state_reg <= S_W_ST;
      end
      else if (pend_reg && acc_done)
      begin
        pend_reg <= 1'b0;
        case (state_reg)
          S_I_DIV: state_reg <= S_I_ADR;
          S_I_ADR: state_reg <= S_I_EN;
          S_I_EN: state_reg <= S_I_CHK;
          S_I_CHK:
          begin
            stuck_reg <= acc_rdata[`IC2H_SB_IBB];
            state_reg <= acc_rdata[`IC2H_SB_IBB] ? S_R1 : S_I_MODE;
          end
          S_R1: state_reg <= S_R2;
          S_R2: state_reg <= S_R3;
          S_R3: state_reg <= S_R4;
          S_R4: state_reg <= S_R5;
          S_R5: state_reg <= S_R6;
          S_R6: state_reg <= S_I_MODE;
          S_S_POLL:
            state_reg <= acc_rdata[`IC2H_SB_IBB] ? S_S_POLL : S_S_TX;
          S_S_TX: state_reg <= S_S_MS;
          S_S_MS: state_reg <= S_S_AD;
          S_S_AD: state_reg <= S_S_BB;
          S_S_BB:
            state_reg <= acc_rdata[`IC2H_SB_IBB] ? S_W_IRQ : S_S_BB;
          S_W_ST:
          begin
            // pending flag survives arbitration loss, byte complete does not
            if (acc_rdata[`IC2H_SB_IIF])
            begin
              st_reg <= acc_rdata;
              nack_reg <= acc_rdata[`IC2H_SB_RECEIVED_ACK_BIT];
              arb_reg <= acc_rdata[`IC2H_SB_IAL];
              addressed_as_slave_flag_reg <= acc_rdata[`IC2H_SB_ADDRESSED_AS_SLAVE_FLAG];
              srw_reg <= acc_rdata[`IC2H_SB_SRW];
              state_reg <= S_W_CLR;
            end
          end
          S_W_CLR:
          begin
            if (st_reg[`IC2H_SB_IAL])
              state_reg <= S_IDLE;
            else if (op_reg == `IC2H_OP_START)
              state_reg <= (tx_reg[0] && !nack_reg) ? S_S_RX : S_IDLE;
            else if (op_reg == `IC2H_OP_READ)
              state_reg <= S_Q_DAT;
            else if (op_reg == `IC2H_OP_SLAVE)
              state_reg <= st_reg[`IC2H_SB_ADDRESSED_AS_SLAVE_FLAG] ? S_V_MTX : S_IDLE;
            else
              state_reg <= S_IDLE;
            if (st_reg[`IC2H_SB_IAL] || op_reg == `IC2H_OP_WRITE ||
                (op_reg == `IC2H_OP_SLAVE && !st_reg[`IC2H_SB_ADDRESSED_AS_SLAVE_FLAG]) ||
                (op_reg == `IC2H_OP_START && !(tx_reg[0] && !nack_reg)))
              done_flag_reg <= 1'b1;
          end
          S_S_RX: state_reg <= S_S_DUM;
          S_X_DAT: state_reg <= S_W_IRQ;
          S_Q_DAT:
          begin
            rx_reg <= acc_rdata;
            state_reg <= S_IDLE;
          end
          default: state_reg <= S_IDLE;
        endcase
        if (state_reg == S_I_MODE || state_reg == S_S_DUM || state_reg == S_Q_DAT ||
            state_reg == S_P || state_reg == S_V_MTX)
        begin
          state_reg <= S_IDLE;
          done_flag_reg <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // axi4-lite write path
  // ****************************************
  always @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IC2H_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      div_reg <= 8'h00;
      own_reg <= 8'h00;
      ien_reg <= 1'b0;
      tx_reg <= 8'h00;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_reg && w_have_reg && !s_axi_bvalid)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `IC2H_RESP_OKAY;
        case (word_addr(aw_addr_reg))
          `IC2H_A_CMD: ;
          `IC2H_A_CFG:
          begin
            if (w_strb_reg[0] && !busy)
              div_reg <= w_data_reg[7:0];
            if (w_strb_reg[1] && !busy)
              own_reg <= w_data_reg[15:8];
            if (w_strb_reg[2] && !busy)
              ien_reg <= w_data_reg[16];
          end
          `IC2H_A_TX:
            if (w_strb_reg[0] && !busy)
              tx_reg <= w_data_reg[7:0];
          `IC2H_A_RX, `IC2H_A_STAT: ;
          default: s_axi_bresp <= `IC2H_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  always @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IC2H_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `IC2H_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (word_addr(s_axi_araddr))
          `IC2H_A_CMD: s_axi_rdata <= {29'h0000_0000, op_reg};
          `IC2H_A_CFG: s_axi_rdata <= {15'h0000, ien_reg, own_reg, div_reg};
          `IC2H_A_TX: s_axi_rdata <= {24'h00_0000, tx_reg};
          `IC2H_A_RX: s_axi_rdata <= {24'h00_0000, rx_reg};
          `IC2H_A_STAT:
            s_axi_rdata <= {16'h0000, st_reg, 1'b0, srw_reg, addressed_as_slave_flag_reg, stuck_reg,
                            arb_reg, nack_reg, done_flag_reg, busy};
          default: s_axi_rresp <= `IC2H_RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // ic2h_top

// File: common/ic2h_map.vh
// register map, field positions and command codes of the i2c host sequencer
`ifndef IC2H_MAP_VH
`define IC2H_MAP_VH
// ****************************************
// device register indices on the device port
// ****************************************
`define IC2H_DEV_DIV 3'h0
`define IC2H_DEV_OWN 3'h1
`define IC2H_DEV_CTRL 3'h2
`define IC2H_DEV_STAT 3'h3
`define IC2H_DEV_DATA 3'h4
// ****************************************
// device control and status bits
// ****************************************
`define IC2H_CB_EN 7
`define IC2H_CB_IEN 6
`define IC2H_CB_MASTER_SELECT_BIT 5
`define IC2H_CB_MTX 4
`define IC2H_SB_ICF 7
`define IC2H_SB_ADDRESSED_AS_SLAVE_FLAG 6
`define IC2H_SB_IBB 5
`define IC2H_SB_IAL 4
`define IC2H_SB_SRW 2
`define IC2H_SB_IIF 1
`define IC2H_SB_RECEIVED_ACK_BIT 0
`define IC2H_CTRL_OFF 8'h00
`define IC2H_CTRL_RECOVER 8'hA0
`define IC2H_STAT_CLR_MASK 8'hED
// ****************************************
// host registers on axi4-lite (byte addresses)
// ****************************************
`define IC2H_A_CMD 8'h00
`define IC2H_A_CFG 8'h04
`define IC2H_A_TX 8'h08
`define IC2H_A_RX 8'h0C
`define IC2H_A_STAT 8'h10
`define IC2H_CFG_RESET 32'h0000_0000
// ****************************************
// commands
// ****************************************
`define IC2H_OP_INIT 3'h1
`define IC2H_OP_START 3'h2
`define IC2H_OP_WRITE 3'h3
`define IC2H_OP_READ 3'h4
`define IC2H_OP_STOP 3'h5
`define IC2H_OP_SLAVE 3'h6
`define IC2H_RESP_OKAY 2'h0
`define IC2H_RESP_SLVERR 2'h2
`endif

// File: rtl/ic2h_devport.v
// four-phase register access engine toward the device register port
module ic2h_devport (
  // clock, reset, enable
  input wire clock,
  input wire rst,
  input wire ce,
  // request from the sequencer
  input wire go,
  input wire acc_we,
  input wire [2:0] acc_addr,
  input wire [7:0] acc_wdata,
  output reg done,
  output reg [7:0] rdata_reg,
  // device register port
  output reg dev_req,
  output reg dev_we,
  output reg [2:0] dev_addr,
  output reg [7:0] dev_wdata,
  input wire dev_ack,
  input wire [7:0] dev_rdata
);
  reg ack_m_reg;
  reg ack_s_reg;
  reg [7:0] rd_m_reg;
  reg [7:0] rd_s_reg;
  reg phase_reg;

  // ****************************************
  // synchronisers
  // ****************************************
  always @(posedge clock)
  begin
    if (rst)
    begin
      ack_m_reg <= 1'b0;
      ack_s_reg <= 1'b0;
      rd_m_reg <= 8'h00;
      rd_s_reg <= 8'h00;
    end
    else if (ce)
    begin
      ack_m_reg <= dev_ack;
      ack_s_reg <= ack_m_reg;
      rd_m_reg <= dev_rdata;
      rd_s_reg <= rd_m_reg;
    end
  end

  // ****************************************
  // handshake
  // ****************************************
  // read data is sampled only while ack stands, so it has been stable for two edges
  always @(posedge clock)
  begin
    if (rst)
    begin
      done <= 1'b0;
      rdata_reg <= 8'h00;
      dev_req <= 1'b0;
      dev_we <= 1'b0;
      dev_addr <= 3'h0;
      dev_wdata <= 8'h00;
      phase_reg <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (go && !dev_req && !phase_reg)
      begin
        dev_req <= 1'b1;
        dev_we <= acc_we;
        dev_addr <= acc_addr;
        dev_wdata <= acc_wdata;
      end
      else if (dev_req && ack_s_reg)
      begin
        rdata_reg <= rd_s_reg;
        dev_req <= 1'b0;
        phase_reg <= 1'b1;
      end
      else if (phase_reg && !ack_s_reg)
      begin
        phase_reg <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule // ic2h_devport

// File: sim/ic2h_checker.sv
// port protocol checker for the i2c host sequencer
`include "ic2h_map.vh"
module ic2h_checker #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // axi4-lite
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // device port
  input wire dev_req,
  input wire dev_we,
  input wire [2:0] dev_addr,
  input wire [7:0] dev_wdata,
  input wire dev_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // ****************
  // assertions
  // ****************
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  rd_slverr_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h13 |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  req_hold_a: assert property (
    dev_req && !dev_ack |=> dev_req && $stable({dev_we, dev_addr, dev_wdata}))
    else $error("device request changed before ack");
  ack_release_a: assert property (
    $rose(dev_ack) |-> ##[1:5] !dev_req)
    else $error("device request not released");
  ctrl_enable_a: assert property (
    dev_req && dev_we && dev_addr == `IC2H_DEV_CTRL && dev_wdata[5] |-> dev_wdata[7])
    else $error("master select without enable");
  // recovery write, refused read, data write
  cover property ($rose(dev_req) && dev_we && dev_wdata == `IC2H_CTRL_RECOVER);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property ($rose(dev_req) && dev_we && dev_addr == `IC2H_DEV_DATA);
endmodule // ic2h_checker
bind ic2h_top ic2h_checker #(.ADDR_W(ADDR_W)) u_chk (.clock, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .dev_req, .dev_we, .dev_addr, .dev_wdata, .dev_ack);

// File: sim/ic2h_devmodel.sv
// behavioural model of the serial controller behind the register port
module ic2h_devmodel (
  // clock and reset
  input wire clock,
  input wire rst,
  // register port
  input wire dev_req,
  input wire dev_we,
  input wire [2:0] dev_addr,
  input wire [7:0] dev_wdata,
  output logic dev_ack,
  output logic [7:0] dev_rdata,
  output logic dev_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] div_reg, own_reg, ctrl_reg, stat_reg, data_reg, rx_byte;
  logic nack, saw_recover;
  int lag, pend;
  assign dev_irq = stat_reg[1] & ctrl_reg[6];
  always @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_reg <= 8'h00;
      stat_reg <= 8'h00;
      dev_ack <= 1'b0;
      dev_rdata <= 8'h5A;
      pend <= 0;
      saw_recover <= 1'b0;
    end
    else
    begin
      // stale read data flips so nothing relies on it
      if (!dev_ack)
        dev_rdata <= ~dev_rdata;
      if (pend == 1)
      begin
        stat_reg[7] <= 1'b1;
        stat_reg[1] <= 1'b1;
        stat_reg[0] <= nack;
      end
      if (pend > 0)
        pend <= pend - 1;
      if (!dev_req)
      begin
        dev_ack <= 1'b0;
        lag <= $urandom_range(3, 0);
      end
      else if (!dev_ack && lag > 0)
        lag <= lag - 1;
      else if (!dev_ack)
      begin
        dev_ack <= 1'b1;
        if (dev_we && dev_addr == 3'h0)
          div_reg <= dev_wdata;
        if (dev_we && dev_addr == 3'h1)
          own_reg <= dev_wdata;
        if (dev_we && dev_addr == 3'h2)
        begin
          ctrl_reg <= dev_wdata;
          stat_reg[6] <= 1'b0;
          saw_recover <= saw_recover | (dev_wdata == 8'hA0);
          if (ctrl_reg[5] && !dev_wdata[5])
            stat_reg[5] <= 1'b0;
        end
        if (dev_we && dev_addr == 3'h3)
          stat_reg[1] <= stat_reg[1] & dev_wdata[1];
        if (dev_we && dev_addr == 3'h4)
        begin
          data_reg <= dev_wdata;
          stat_reg[7] <= 1'b0;
          // start waits out the bus free time by itself
          pend <= 6;
          stat_reg[5] <= stat_reg[5] | ctrl_reg[5];
        end
        if (!dev_we)
          dev_rdata <= dev_addr == 3'h3 ? stat_reg : dev_addr == 3'h2 ? ctrl_reg : rx_byte;
        if (!dev_we && dev_addr == 3'h4 && !ctrl_reg[4])
        begin
          // a data read in receive starts the next byte
          stat_reg[7] <= 1'b0;
          pend <= 6;
        end
      end
    end
  end
endmodule // ic2h_devmodel

// File: sim/ic2h_top_tb.sv
// self-checking bench for the i2c host sequencer
`include "ic2h_map.vh"
module ic2h_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, b, o;
  logic [31:0] wdata = 32'h0000_0000, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, dev_req, dev_we, dev_ack, dev_irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] dev_addr;
  wire [7:0] dev_wdata, dev_rdata;
  logic [33:0] exp_q[$], msk_q[$];
  int fail_count = 0, checks_done = 0;
  always #2.5 clock = ~clock;
  ic2h_top #(.ADDR_W(8)) u_dut (.clock(clock), .rst(rst), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dev_req(dev_req), .dev_we(dev_we), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_ack(dev_ack), .dev_rdata(dev_rdata), .dev_irq(dev_irq));
  ic2h_devmodel u_dev (.clock(clock), .rst(rst), .dev_req(dev_req), .dev_we(dev_we),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
    .dev_irq(dev_irq));
  // ****************
  // shared tasks
  // ****************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic guard(input int n, input int lim);
    if (n >= lim)
    begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic dchk(input logic [7:0] s, input logic [7:0] e);
    chk({26'h000_0000, s}, {26'h000_0000, e});
  endtask
  // answers are judged as they appear, oldest note first
  always @(posedge clock)
    if ((bvalid && bready) || (rvalid && rready))
    begin
      chk((bvalid ? {bresp, 32'h0000_0000} : {rresp, rdata}) & msk_q[0], exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    exp_q.push_back({r, 32'h0000_0000});
    msk_q.push_back({2'h3, 32'hFFFF_FFFF});
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      n++;
    end
    while (!bvalid && n < 50);
    bready <= 1'b0;
    guard(n, 50);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] e,
    input logic [31:0] m);
    int n = 0;
    exp_q.push_back({r, e & m});
    msk_q.push_back({2'h3, m});
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready)
        arvalid <= 1'b0;
      n++;
    end
    while (!rvalid && n < 50);
    v = rdata;
    rready <= 1'b0;
    guard(n, 50);
  endtask
  task automatic run(input logic [2:0] op);
    int n = 0;
    axi_wr(`IC2H_A_CMD, {29'h0000_0000, op}, `IC2H_RESP_OKAY);
    do
    begin
      axi_rd(`IC2H_A_STAT, 2'h0, 32'h0000_0000, 32'h0000_0000);
      n++;
    end
    while (!v[1] && n < 200);
    guard(n, 200);
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    u_dev.nack = 1'b0;
    u_dev.rx_byte = 8'h00;
    void'($urandom(57));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    axi_rd(`IC2H_A_CMD, 2'h0, 32'h0000_0000, 32'hFFFF_FFFF);
    axi_rd(`IC2H_A_CFG, 2'h0, `IC2H_CFG_RESET, 32'hFFFF_FFFF);
    axi_rd(8'h14, `IC2H_RESP_SLVERR, 32'h0000_0000, 32'hFFFF_FFFF);
    axi_wr(8'h20, 32'h0000_00FF, `IC2H_RESP_SLVERR);
    $display("test reset done");
    // bus found stuck busy at enable
    u_dev.stat_reg[5] <= 1'b1;
    b = $urandom;
    o = $urandom;
    axi_wr(`IC2H_A_CFG, {16'h0000, o, b}, 2'h0);
    run(`IC2H_OP_INIT);
    dchk(u_dev.div_reg, b);
    dchk(u_dev.own_reg, o);
    dchk(u_dev.ctrl_reg, 8'h80);
    dchk({7'h00, u_dev.saw_recover}, 8'h01);
    dchk({7'h00, u_dev.stat_reg[5]}, 8'h00);
    axi_rd(`IC2H_A_STAT, 2'h0, 32'h0000_0010, 32'h0000_0010);
    $display("test init done");
    b = $urandom;
    b[0] = 1'b0;
    axi_wr(`IC2H_A_TX, {24'h00_0000, b}, 2'h0);
    run(`IC2H_OP_START);
    dchk(u_dev.data_reg, b);
    dchk({7'h00, u_dev.stat_reg[5]}, 8'h01);
    axi_rd(`IC2H_A_STAT, 2'h0, 32'h0000_0000, 32'h0000_0004);
    u_dev.nack <= 1'b1;
    b = $urandom;
    axi_wr(`IC2H_A_TX, {24'h00_0000, b}, 2'h0);
    run(`IC2H_OP_WRITE);
    dchk(u_dev.data_reg, b);
    axi_rd(`IC2H_A_STAT, 2'h0, 32'h0000_0004, 32'h0000_0004);
    u_dev.nack <= 1'b0;
    run(`IC2H_OP_STOP);
    dchk(u_dev.ctrl_reg, 8'h80);
    $display("test master write done");
    axi_wr(`IC2H_A_CFG, {15'h0000, 1'b1, o, b}, 2'h0);
    run(`IC2H_OP_INIT);
    dchk(u_dev.ctrl_reg, 8'hC0);
    b = $urandom;
    b[0] = 1'b1;
    axi_wr(`IC2H_A_TX, {24'h00_0000, b}, 2'h0);
    run(`IC2H_OP_START);
    dchk(u_dev.ctrl_reg, 8'hE0);
    o = $urandom;
    u_dev.rx_byte <= o;
    run(`IC2H_OP_READ);
    axi_rd(`IC2H_A_RX, 2'h0, {24'h00_0000, o}, 32'h0000_00FF);
    run(`IC2H_OP_STOP);
    $display("test master read done");
    // address match with the master reading from us
    u_dev.stat_reg <= u_dev.stat_reg | 8'h46;
    run(`IC2H_OP_SLAVE);
    dchk(u_dev.ctrl_reg, 8'hD0);
    dchk({7'h00, u_dev.stat_reg[6]}, 8'h00);
    $display("test slave done");
    give_verdict();
  end
endmodule // ic2h_top_tb
